// ===== dv/test_pll_divider_nco_spread_control.sv
`timescale 1ns/1ns
`include "pndc_cfg.svh"
module test_pll_divider_nco_spread_control;
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] w;
    logic [31:0] r;
    logic [1:0] e;
  } pndc_row_t;
  logic sys_clk;
  logic rst_n;
  pndc_pkg::pndc_axi_req_t req;
  pndc_pkg::pndc_axi_rsp_t rsp;
  logic [3:0] gpio_pins;
  logic pll_lock_pin;
  pndc_pkg::pndc_fb_t fb;
  pndc_pkg::pndc_fr_t fr;
  logic pll_locked_flag;
  int miscompares;
  int check_count;
  logic [31:0] rd_d;
  logic [1:0] rd_r;
  logic [41:0] nom;
  logic [41:0] stp;
  logic [41:0] dev;
  pndc_row_t rows [14];

  pndc_top dut (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .axi_req(req),
    .axi_rsp(rsp),
    .gpio_pins(gpio_pins),
    .pll_lock_pin(pll_lock_pin),
    .fb_divider_out(fb),
    .frac_divider_out(fr),
    .pll_locked_flag(pll_locked_flag)
  );

  // Free-running 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Every comparison is counted; X never matches
  task automatic chk(input string n, input logic [41:0] e,
                     input logic [41:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s exp %h got %h", n, e, g);
    end
  endtask : chk

  task automatic test_done();
    if (miscompares == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done

  // Write: AW and W offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] e);
    @(posedge sys_clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.bready <= 1'b1;
    // Waits for bvalid; only the watchdog ends a wait that never sees it
    do begin
      @(posedge sys_clk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    req.bready <= 1'b0;
    chk("bresp", 42'(e), 42'(rsp.bresp));
  endtask : wr

  // Read: data captured at the edge that shows rvalid
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    rd_d = rsp.rdata;
    rd_r = rsp.rresp;
    req.rready <= 1'b0;
  endtask : rd

  // Toggle one pin; sync stages plus update need three edges
  task automatic tg(input int b);
    @(posedge sys_clk);
    gpio_pins[b] <= ~gpio_pins[b];
    repeat (5) @(posedge sys_clk);
  endtask : tg

  // Spread: start from idle, then track the ramp extremes
  task automatic spr(input logic [31:0] c, input logic [41:0] hi,
                     input logic [41:0] lo);
    logic [41:0] mx;
    logic [41:0] mn;
    wr(`PNDC_OFF_CTRL, 32'h0000_0000, `PNDC_RESP_OKAY);
    repeat (3) @(posedge sys_clk);
    wr(`PNDC_OFF_CTRL, c, `PNDC_RESP_OKAY);
    repeat (6) @(posedge sys_clk);
    mx = fb.value;
    mn = fb.value;
    repeat (40) begin
      @(posedge sys_clk);
      if (fb.value > mx) mx = fb.value;
      if (fb.value < mn) mn = fb.value;
    end
    chk("spr_max", hi, mx);
    chk("spr_min", lo, mn);
  endtask : spr

  // Hang guard; a full run needs about five hundred cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    test_done();
  end

  // Main sequence
  initial begin
    rst_n = 1'b0;
    req = '0;
    req.wstrb = 4'hf;
    gpio_pins = 4'h0;
    pll_lock_pin = 1'b0;
    miscompares = 0;
    check_count = 0;
    nom = 42'h000_0040_0000;
    stp = 42'h000_0000_0200;
    dev = 42'h000_0000_0010;
    rows[0] = '{8'h08, 32'h1234_5678, 32'h1234_5678, 2'h0};
    rows[1] = '{8'h0c, 32'hffff_ffff, 32'h0000_03ff, 2'h0};
    rows[2] = '{8'h10, 32'ha5a5_a5a5, 32'ha5a5_a5a5, 2'h0};
    rows[3] = '{8'h14, 32'h0000_0007, 32'h0000_0007, 2'h0};
    rows[4] = '{8'h18, 32'hffff_ffff, 32'h0000_003f, 2'h0};
    rows[5] = '{8'h1c, 32'h8765_4321, 32'h8765_4321, 2'h0};
    rows[6] = '{8'h20, 32'hffff_ffff, 32'h0000_00ff, 2'h0};
    rows[7] = '{8'h24, 32'h5a5a_5a5a, 32'h5a5a_5a5a, 2'h0};
    rows[8] = '{8'h28, 32'h0000_0003, 32'h0000_0003, 2'h0};
    rows[9] = '{8'h2c, 32'hffff_ffff, 32'h0000_003f, 2'h0};
    rows[10] = '{8'h30, 32'hffff_ffff, 32'h00ff_ffff, 2'h0};
    rows[11] = '{8'h34, 32'hffff_ffff, 32'h0000_ffff, 2'h0};
    rows[12] = '{8'h3c, 32'h1234_5678, 32'h0000_0000, 2'h2};
    rows[13] = '{8'h04, 32'hffff_ffff, 32'h0000_0000, 2'h0};
    repeat (16) @(posedge sys_clk);
    chk("den_rst", 42'h1, 42'(fb.den));
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd(`PNDC_OFF_CTRL);
    chk("ctrl_rst", 42'h0, 42'(rd_d));
    // Register map: write, read back, and check response codes
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w, rows[i].e);
      rd(rows[i].a);
      chk("rdata", 42'(rows[i].r), 42'(rd_d));
      chk("rresp", 42'(rows[i].e), 42'(rd_r));
    end
    chk("fb_out", {10'h3ff, 32'h1234_5678}, fb.value);
    chk("fr_out", 42'({8'hff, 32'h8765_4321}), 42'(fr.value));
    chk("fb_rem", 42'(32'ha5a5_a5a5), 42'(fb.rem));
    chk("fb_bp", 42'h3f, 42'(fb.bp));
    // Fractional NCO: nominal 0x800000 over one plus 100ppm, plain integer
    wr(`PNDC_OFF_FR_REM, 32'h0000_0000, `PNDC_RESP_OKAY);
    wr(`PNDC_OFF_FR_DEN, 32'h0000_0001, `PNDC_RESP_OKAY);
    wr(`PNDC_OFF_FR_BP, 32'h0000_0000, `PNDC_RESP_OKAY);
    wr(`PNDC_OFF_FR_HI, 32'h0000_0000, `PNDC_RESP_OKAY);
    wr(`PNDC_OFF_FR_LO, 32'h007f_fcb9, `PNDC_RESP_OKAY);
    chk("nco_fr", 42'h000_007f_fcb9, 42'(fr.value));
    chk("fr_den", 42'h1, 42'(fr.den));
    // Plain integer divider set-up, then lock the loop
    wr(`PNDC_OFF_FB_LO, 32'h0040_0000, `PNDC_RESP_OKAY);
    wr(`PNDC_OFF_FB_HI, 32'h0000_0000, `PNDC_RESP_OKAY);
    wr(`PNDC_OFF_FB_REM, 32'h0000_0000, `PNDC_RESP_OKAY);
    wr(`PNDC_OFF_FB_DEN, 32'h0000_0001, `PNDC_RESP_OKAY);
    wr(`PNDC_OFF_FB_BP, 32'h0000_0000, `PNDC_RESP_OKAY);
    wr(`PNDC_OFF_STEP, 32'h0000_0004, `PNDC_RESP_OKAY);
    wr(`PNDC_OFF_CNT, 32'h0000_0002, `PNDC_RESP_OKAY);
    pll_lock_pin <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk("lock", 42'h1, 42'(pll_locked_flag));
    rd(`PNDC_OFF_STATUS);
    chk("stat_lock", 42'h1, 42'(rd_d[0]));
    // NCO steering: +100ppm then -100ppm, both computed from nominal
    wr(`PNDC_OFF_FB_LO, 32'h0040_01a3, `PNDC_RESP_OKAY);
    repeat (2) @(posedge sys_clk);
    chk("nco_up", 42'h000_0040_01a3, fb.value);
    wr(`PNDC_OFF_FB_LO, 32'h003f_fe5d, `PNDC_RESP_OKAY);
    repeat (2) @(posedge sys_clk);
    chk("nco_dn", 42'h000_003f_fe5d, fb.value);
    wr(`PNDC_OFF_FB_LO, 32'h0040_0000, `PNDC_RESP_OKAY);
    repeat (2) @(posedge sys_clk);
    chk("nco_nom", nom, fb.value);
    // Software trigger: both edges of the bit count as changes
    wr(`PNDC_OFF_CTRL, 32'h0000_0001, `PNDC_RESP_OKAY);
    wr(`PNDC_OFF_CTRL, 32'h0000_4001, `PNDC_RESP_OKAY);
    repeat (2) @(posedge sys_clk);
    chk("inc_sw", nom + stp, fb.value);
    wr(`PNDC_OFF_CTRL, 32'h0000_0001, `PNDC_RESP_OKAY);
    wr(`PNDC_OFF_CTRL, 32'h0000_0151, `PNDC_RESP_OKAY);
    tg(1);
    chk("inc_pin", nom + 3 * stp, fb.value);
    tg(0);
    tg(0);
    chk("dec_pin", nom + stp, fb.value);
    rd(`PNDC_OFF_FB_LO);
    chk("rd_cur", 42'(32'h0040_0200), 42'(rd_d));
    wr(`PNDC_OFF_CTRL, 32'h0000_0141, `PNDC_RESP_OKAY);
    rd(`PNDC_OFF_FB_LO);
    chk("rd_nom", 42'(32'h0040_0000), 42'(rd_d));
    // Lock loss: triggers ignored, nominal restored on relock
    pll_lock_pin <= 1'b0;
    repeat (4) @(posedge sys_clk);
    tg(1);
    pll_lock_pin <= 1'b1;
    repeat (5) @(posedge sys_clk);
    chk("relock", nom, fb.value);
    tg(1);
    chk("inc_relock", nom + stp, fb.value);
    // Clearing the enable drops back at once and stops stepping
    wr(`PNDC_OFF_CTRL, 32'h0000_0140, `PNDC_RESP_OKAY);
    repeat (2) @(posedge sys_clk);
    chk("en_clr", nom, fb.value);
    tg(1);
    chk("en_off", nom, fb.value);
    wr(`PNDC_OFF_CTRL, 32'h0000_0149, `PNDC_RESP_OKAY);
    tg(1);
    chk("fsel", nom, fb.value);
    // Triangle modulation: four cycles a segment, unshifted step
    spr(32'h0000_0002, nom + dev, nom - dev);
    spr(32'h0000_0006, nom, nom - dev);
    @(posedge sys_clk);
    gpio_pins[2] <= 1'b1;
    spr(32'h0000_1800, nom + dev, nom - dev);
    pll_lock_pin <= 1'b0;
    spr(32'h0000_1800, nom, nom);
    test_done();
  end
endmodule : test_pll_divider_nco_spread_control

// ===== rtl/pndc_cfg.svh
// Summary of operation
// - With feedback selected, increment trigger change adds step shifted by seven.
// - Decrement trigger change subtracts step shifted by seven.
// - Divider reads give current value when read-current set, else nominal.
// - Steps apply only while locked; trigger changes otherwise ignored.
// - After lock loss, divider returns to nominal when lock returns.
// - Stepping needs its enable; clearing it returns divider to nominal.
// - Spread enabled by its enable bit or a selected GPIO pin.
// - With feedback selected, spread varies divider starting at nominal.
// - Down select zero gives triangle center spread.
// - Down select one gives triangle down spread below nominal.
// - Spread uses plain integer divider settings and runs only while locked.
// - A status flag shows live lock state.
// - Divider is 9 integer bits plus up to 33 fraction bits.
`ifndef PNDC_CFG_SVH
`define PNDC_CFG_SVH
`define PNDC_OFF_CTRL 8'h00
`define PNDC_OFF_STATUS 8'h04
`define PNDC_OFF_FB_LO 8'h08
`define PNDC_OFF_FB_HI 8'h0C
`define PNDC_OFF_FB_REM 8'h10
`define PNDC_OFF_FB_DEN 8'h14
`define PNDC_OFF_FB_BP 8'h18
`define PNDC_OFF_FR_LO 8'h1C
`define PNDC_OFF_FR_HI 8'h20
`define PNDC_OFF_FR_REM 8'h24
`define PNDC_OFF_FR_DEN 8'h28
`define PNDC_OFF_FR_BP 8'h2C
`define PNDC_OFF_STEP 8'h30
`define PNDC_OFF_CNT 8'h34
`define PNDC_CTL_STEP_EN 0
`define PNDC_CTL_SPR_EN 1
`define PNDC_CTL_DOWN 2
`define PNDC_CTL_FSEL 3
`define PNDC_CTL_RDCUR 4
`define PNDC_CTL_INC_SRC 5
`define PNDC_CTL_DEC_SRC 8
`define PNDC_CTL_SPR_SRC 11
`define PNDC_CTL_SW_INC 14
`define PNDC_CTL_SW_DEC 15
`define PNDC_STAT_LOCK 0
`define PNDC_STAT_SPR 1
`define PNDC_STAT_STEP 2
`define PNDC_STEP_SHIFT 7
`define PNDC_RST_CTRL 16'h0000
`define PNDC_RST_DEN 32'h0000_0001
`define PNDC_RESP_OKAY 2'h0
`define PNDC_RESP_SLVERR 2'h2
`endif

// ===== rtl/pndc_pkg.sv
package pndc_pkg;
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } pndc_axi_req_t;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } pndc_axi_rsp_t;
  typedef struct packed {
    logic [41:0] value;
    logic [31:0] rem;
    logic [31:0] den;
    logic [5:0] bp;
  } pndc_fb_t;
  typedef struct packed {
    logic [39:0] value;
    logic [31:0] rem;
    logic [31:0] den;
    logic [5:0] bp;
  } pndc_fr_t;
  typedef struct packed {
    pndc_axi_rsp_t rsp;
    logic aw_have;
    logic [7:0] awaddr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [15:0] ctrl;
    pndc_fb_t fb;
    pndc_fr_t fr;
    logic [23:0] step;
    logic [15:0] cnt;
    logic [41:0] cur;
    logic [16:0] seg;
    logic [1:0] ph;
    logic [3:0] gpio_s1;
    logic [3:0] gpio_s2;
    logic lock_s1;
    logic lock_s2;
    logic inc_prev;
    logic dec_prev;
  } pndc_state_t;
endpackage : pndc_pkg

// ===== rtl/pndc_top.sv
`timescale 1ns/1ns
`include "pndc_cfg.svh"
module pndc_top (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire pndc_pkg::pndc_axi_req_t axi_req,
  output pndc_pkg::pndc_axi_rsp_t axi_rsp,
  input wire logic [3:0] gpio_pins,
  input wire logic pll_lock_pin,
  output pndc_pkg::pndc_fb_t fb_divider_out,
  output pndc_pkg::pndc_fr_t frac_divider_out,
  output logic pll_locked_flag
);
  pndc_pkg::pndc_state_t s_q;
  pndc_pkg::pndc_state_t s_d;
  logic [1:0] rst_sync_q;
  logic rst_ok;
  logic step_act;
  logic spr_act;
  logic inc_now;
  logic dec_now;
  logic inc_chg;
  logic dec_chg;
  logic spr_pin;
  logic ramp_up;
  logic [31:0] wval;

  // Trigger or pin-source select: 0 is the software bit, 1 to 4 a GPIO
  function automatic logic pick_src(input logic [2:0] src,
                                    input logic sw,
                                    input logic [3:0] pins);
    logic r;
    r = 1'b0;
    case (src)
      3'h0: r = sw;
      3'h1: r = pins[0];
      3'h2: r = pins[1];
      3'h3: r = pins[2];
      3'h4: r = pins[3];
      default: r = 1'b0;
    endcase
    return r;
  endfunction : pick_src

  // Byte-lane merge for partial writes
  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : wmerge

  // Read mux; feedback divider value words follow the read-current select
  function automatic logic [32:0] rd_word(input logic [7:0] a,
                                          input pndc_pkg::pndc_state_t s,
                                          input logic sa,
                                          input logic ta);
    logic [32:0] r;
    logic [41:0] fbv;
    r = 33'h0_0000_0000;
    fbv = s.ctrl[`PNDC_CTL_RDCUR] ? s.cur : s.fb.value;
    case (a)
      `PNDC_OFF_CTRL: r[15:0] = s.ctrl;
      `PNDC_OFF_STATUS: r[2:0] = {ta, sa, s.lock_s2};
      `PNDC_OFF_FB_LO: r[31:0] = fbv[31:0];
      `PNDC_OFF_FB_HI: r[9:0] = fbv[41:32];
      `PNDC_OFF_FB_REM: r[31:0] = s.fb.rem;
      `PNDC_OFF_FB_DEN: r[31:0] = s.fb.den;
      `PNDC_OFF_FB_BP: r[5:0] = s.fb.bp;
      `PNDC_OFF_FR_LO: r[31:0] = s.fr.value[31:0];
      `PNDC_OFF_FR_HI: r[7:0] = s.fr.value[39:32];
      `PNDC_OFF_FR_REM: r[31:0] = s.fr.rem;
      `PNDC_OFF_FR_DEN: r[31:0] = s.fr.den;
      `PNDC_OFF_FR_BP: r[5:0] = s.fr.bp;
      `PNDC_OFF_STEP: r[23:0] = s.step;
      `PNDC_OFF_CNT: r[15:0] = s.cnt;
      default: r[32] = 1'b1; // Unmapped address
    endcase
    return r;
  endfunction : rd_word

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_ok = rst_sync_q[1];

  // Mode decode from registered, synchronised state
  always_comb begin
    inc_now = pick_src(s_q.ctrl[`PNDC_CTL_INC_SRC +: 3],
                       s_q.ctrl[`PNDC_CTL_SW_INC], s_q.gpio_s2);
    dec_now = pick_src(s_q.ctrl[`PNDC_CTL_DEC_SRC +: 3],
                       s_q.ctrl[`PNDC_CTL_SW_DEC], s_q.gpio_s2);
    spr_pin = pick_src(s_q.ctrl[`PNDC_CTL_SPR_SRC +: 3], 1'b0,
                       s_q.gpio_s2);
    inc_chg = inc_now ^ s_q.inc_prev;
    dec_chg = dec_now ^ s_q.dec_prev;
    // Modulation only with feedback divider selected and PLL locked
    spr_act = (s_q.ctrl[`PNDC_CTL_SPR_EN] | spr_pin)
              & ~s_q.ctrl[`PNDC_CTL_FSEL] & s_q.lock_s2;
    // Spread wins if software breaks the exclusion of the shared step
    step_act = s_q.ctrl[`PNDC_CTL_STEP_EN] & ~s_q.ctrl[`PNDC_CTL_FSEL]
               & s_q.lock_s2 & ~spr_act;
    if (s_q.ctrl[`PNDC_CTL_DOWN]) begin
      ramp_up = s_q.ph[0];
    end else begin
      ramp_up = (s_q.ph == 2'h0) || (s_q.ph == 2'h3);
    end
  end

  // Next state: bus slave, synchronisers and divider engine
  always_comb begin
    logic [32:0] rd;
    rd = 33'h0_0000_0000;
    wval = 32'h0000_0000;
    s_d = s_q;
    s_d.gpio_s1 = gpio_pins;
    s_d.gpio_s2 = s_q.gpio_s1;
    s_d.lock_s1 = pll_lock_pin;
    s_d.lock_s2 = s_q.lock_s1;
    s_d.inc_prev = inc_now;
    s_d.dec_prev = dec_now;
    // Divider engine; unlocked or idle it tracks nominal
    if (step_act) begin
      if (inc_chg) begin
        s_d.cur = s_d.cur + {11'h0, s_q.step, 7'h0};
      end
      if (dec_chg) begin
        s_d.cur = s_d.cur - {11'h0, s_q.step, 7'h0};
      end
    end else if (spr_act) begin
      // Triangle from nominal: one step each clock, turn every count+2
      if (ramp_up) begin
        s_d.cur = s_q.cur + {18'h0, s_q.step};
      end else begin
        s_d.cur = s_q.cur - {18'h0, s_q.step};
      end
      if (s_q.seg >= {1'b0, s_q.cnt} + 17'h0_0001) begin
        s_d.seg = 17'h0_0000;
        s_d.ph = s_q.ph + 2'h1;
      end else begin
        s_d.seg = s_q.seg + 17'h0_0001;
      end
    end else begin
      s_d.cur = s_q.fb.value;
      s_d.seg = 17'h0_0000;
      s_d.ph = 2'h0;
    end
    // Read channel: clear on handshake, then accept the next address
    if (s_q.rsp.rvalid && axi_req.rready) begin
      s_d.rsp.rvalid = 1'b0;
    end
    if (axi_req.arvalid && s_q.rsp.arready) begin
      rd = rd_word(axi_req.araddr, s_q, spr_act, step_act);
      s_d.rsp.rvalid = 1'b1;
      s_d.rsp.rdata = rd[31:0];
      s_d.rsp.rresp = rd[32] ? `PNDC_RESP_SLVERR : `PNDC_RESP_OKAY;
    end
    // Write channel: address and data taken in either order
    if (s_q.rsp.bvalid && axi_req.bready) begin
      s_d.rsp.bvalid = 1'b0;
    end
    if (axi_req.awvalid && s_q.rsp.awready) begin
      s_d.aw_have = 1'b1;
      s_d.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && s_q.rsp.wready) begin
      s_d.w_have = 1'b1;
      s_d.wdata = axi_req.wdata;
      s_d.wstrb = axi_req.wstrb;
    end
    if (s_q.aw_have && s_q.w_have && !s_q.rsp.bvalid) begin
      rd = rd_word(s_q.awaddr, s_q, spr_act, step_act);
      // Partial divider writes merge with nominal, never the stepped value
      if (s_q.awaddr == `PNDC_OFF_FB_LO) begin
        rd[31:0] = s_q.fb.value[31:0];
      end
      if (s_q.awaddr == `PNDC_OFF_FB_HI) begin
        rd[31:0] = {22'h00_0000, s_q.fb.value[41:32]};
      end
      wval = wmerge(rd[31:0], s_q.wdata, s_q.wstrb);
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.rsp.bvalid = 1'b1;
      s_d.rsp.bresp = rd[32] ? `PNDC_RESP_SLVERR : `PNDC_RESP_OKAY;
      // High divider word is read-merged with the nominal copy
      case (s_q.awaddr)
        `PNDC_OFF_CTRL: s_d.ctrl = wval[15:0];
        `PNDC_OFF_FB_LO: s_d.fb.value[31:0] = wval;
        `PNDC_OFF_FB_HI: s_d.fb.value[41:32] = wval[9:0];
        `PNDC_OFF_FB_REM: s_d.fb.rem = wval;
        `PNDC_OFF_FB_DEN: s_d.fb.den = wval;
        `PNDC_OFF_FB_BP: s_d.fb.bp = wval[5:0];
        `PNDC_OFF_FR_LO: s_d.fr.value[31:0] = wval;
        `PNDC_OFF_FR_HI: s_d.fr.value[39:32] = wval[7:0];
        `PNDC_OFF_FR_REM: s_d.fr.rem = wval;
        `PNDC_OFF_FR_DEN: s_d.fr.den = wval;
        `PNDC_OFF_FR_BP: s_d.fr.bp = wval[5:0];
        `PNDC_OFF_STEP: s_d.step = wval[23:0];
        `PNDC_OFF_CNT: s_d.cnt = wval[15:0];
        default: s_d.ctrl = s_q.ctrl; // Status and holes are read-only
      endcase
    end
    s_d.rsp.awready = !s_d.aw_have && !s_d.rsp.bvalid;
    s_d.rsp.wready = !s_d.w_have && !s_d.rsp.bvalid;
    s_d.rsp.arready = !s_d.rsp.rvalid;
  end

  // State register; denominators reset to one for a plain integer divide
  always_ff @(posedge sys_clk or negedge rst_ok) begin
    if (!rst_ok) begin
      s_q <= '0;
      s_q.ctrl <= `PNDC_RST_CTRL;
      s_q.fb.den <= `PNDC_RST_DEN;
      s_q.fr.den <= `PNDC_RST_DEN;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state flops; fractional NCO writes land directly, feedback ones reach cur a cycle later when idle
  assign axi_rsp = s_q.rsp;
  assign fb_divider_out = '{value: s_q.cur, rem: s_q.fb.rem,
                            den: s_q.fb.den, bp: s_q.fb.bp};
  assign frac_divider_out = s_q.fr;
  assign pll_locked_flag = s_q.lock_s2;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_ok);

  property p_step_inc;
    step_act && inc_chg && !dec_chg |=>
      s_q.cur == $past(s_q.cur) + {11'h0, $past(s_q.step), 7'h0};
  endproperty
  a_step_inc: assert property (p_step_inc)
    else $error("increment step not applied");
  property p_step_dec;
    step_act && dec_chg && !inc_chg |=>
      s_q.cur == $past(s_q.cur) - {11'h0, $past(s_q.step), 7'h0};
  endproperty
  a_step_dec: assert property (p_step_dec)
    else $error("decrement step not applied");
  property p_rd_fb;
    axi_req.arvalid && s_q.rsp.arready &&
      axi_req.araddr == `PNDC_OFF_FB_LO |=>
      s_q.rsp.rvalid && s_q.rsp.rdata == ($past(s_q.ctrl[`PNDC_CTL_RDCUR])
        ? $past(s_q.cur[31:0]) : $past(s_q.fb.value[31:0]));
  endproperty
  a_rd_fb: assert property (p_rd_fb)
    else $error("divider read source wrong");
  property p_unlocked;
    !s_q.lock_s2 ##1 !s_q.lock_s2 |-> s_q.cur == $past(s_q.fb.value);
  endproperty
  a_unlocked: assert property (p_unlocked)
    else $error("divider moved while unlocked");
  property p_relock;
    $rose(s_q.lock_s2) |-> s_q.cur == $past(s_q.fb.value);
  endproperty
  a_relock: assert property (p_relock)
    else $error("divider not nominal on relock");
  property p_step_off;
    $fell(s_q.ctrl[`PNDC_CTL_STEP_EN]) && !spr_act |=>
      s_q.cur == $past(s_q.fb.value);
  endproperty
  a_step_off: assert property (p_step_off)
    else $error("step disable did not restore nominal");
  property p_lock_stat;
    axi_req.arvalid && s_q.rsp.arready &&
      axi_req.araddr == `PNDC_OFF_STATUS |=>
      s_q.rsp.rdata[`PNDC_STAT_LOCK] == $past(s_q.lock_s2);
  endproperty
  a_lock_stat: assert property (p_lock_stat)
    else $error("lock status wrong");
  property p_turn;
    spr_act && s_q.seg == {1'b0, s_q.cnt} + 17'h0_0001 |=>
      s_q.ph == $past(s_q.ph) + 2'h1 && s_q.seg == 17'h0_0000;
  endproperty
  a_turn: assert property (p_turn)
    else $error("ramp did not turn after count plus two");
  property p_down;
    spr_act && s_q.ctrl[`PNDC_CTL_DOWN] && !s_q.ph[0] |=>
      s_q.cur == $past(s_q.cur) - {18'h0, $past(s_q.step)};
  endproperty
  a_down: assert property (p_down)
    else $error("down spread not ramping down");
  property p_center;
    spr_act && !s_q.ctrl[`PNDC_CTL_DOWN] && s_q.ph == 2'h0 |=>
      s_q.cur == $past(s_q.cur) + {18'h0, $past(s_q.step)};
  endproperty
  a_center: assert property (p_center)
    else $error("center spread not ramping up first");
  property p_fsel;
    s_q.ctrl[`PNDC_CTL_FSEL] |=> s_q.cur == $past(s_q.fb.value);
  endproperty
  a_fsel: assert property (p_fsel)
    else $error("feedback moved with fractional select");
  c_step: cover property (step_act && inc_chg);
  c_turn: cover property (spr_act && s_q.ph == 2'h3);
  c_relock: cover property ($rose(s_q.lock_s2));
  c_err: cover property (s_q.rsp.rvalid && s_q.rsp.rresp != 2'h0);
endmodule : pndc_top
